// ### sccr_pkg.sv
/*
 * Constants, field positions and types shared by the system control
 * and configuration register block and its low-power sequencer.
 * Assumes an 8-bit internal I/O bus where only the low eight address
 * lines are decoded.
 */
package sccr_pkg;

    // ************************************************************
    // Register addresses (low eight I/O address bits)
    // ************************************************************
    localparam logic [7:0] ADDR_CPU_CONTROL = 8'h1F;
    localparam logic [7:0] ADDR_LP_STATUS = 8'h1E;
    localparam logic [7:0] ADDR_IO_CONTROL = 8'h3F;
    localparam logic [7:0] ADDR_RAM_UPPER = 8'hE6;
    localparam logic [7:0] ADDR_RAM_LOWER = 8'hE7;
    localparam logic [7:0] ADDR_SYS_CONFIG = 8'hEF;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int unsigned CCR_CLK_DIV1_BIT = 7;
    localparam int unsigned CCR_LP_HI_BIT = 6;
    localparam int unsigned CCR_BUS_GRANT_BIT = 5;
    localparam int unsigned CCR_LN_CLOCK_BIT = 4;
    localparam int unsigned CCR_LP_LO_BIT = 3;
    localparam int unsigned CCR_LN_CTRL_BIT = 1;
    localparam int unsigned CCR_LN_AD_BIT = 0;
    localparam int unsigned SCR_ROM_DISABLE_BIT = 3;
    localparam int unsigned SCR_TRIMUX_HI_BIT = 2;
    localparam int unsigned SCR_MODE_BIT = 1;
    localparam int unsigned SCR_DAISY_BIT = 0;
    localparam int unsigned ICR_IO_HALT_BIT = 5;

    // ************************************************************
    // Masks and reset values
    // ************************************************************
    localparam logic [7:0] CCR_WRITE_MASK = 8'hFB;
    localparam logic [7:0] CCR_RESET = 8'h00;
    localparam logic [7:0] SCR_RESET = 8'h00;
    localparam logic [7:0] RAM_BOUND_RESET = 8'h00;
    localparam logic [7:0] READ_IDLE = 8'h00;

    // ************************************************************
    // Recovery counts in clock cycles
    // ************************************************************
    localparam int unsigned STANDBY_WAKE_CYCLES = 131072;
    localparam int unsigned QUICK_WAKE_CYCLES = 64;
    localparam int unsigned IDLE_WAKE_CYCLES = 8;
    localparam int unsigned CNT_W = 18;

    // Low-power select, coded as {bit 6, bit 3}.
    typedef enum logic [1:0] {
        LP_NONE = 2'b00,
        LP_IDLE = 2'b01,
        LP_STANDBY = 2'b10,
        LP_QUICK = 2'b11
    } sccr_lp_mode_type;

    typedef enum logic [1:0] {
        LPS_RUN = 2'b00,
        LPS_ASLEEP = 2'b01,
        LPS_RECOVER = 2'b11
    } sccr_lp_state_type;

    typedef enum logic [1:0] {
        TRIMUX_DMA = 2'b00,
        TRIMUX_CHANB = 2'b01,
        TRIMUX_HOST = 2'b10
    } sccr_trimux_type;

endpackage

// ### sccr_lp_if.sv
/*
 * Link between the register block and the low-power sequencer.
 * Both ends run on the same clock and reset.
 */
`timescale 1ns/1ps
interface sccr_lp_if;
    import sccr_pkg::*;
    logic sleep_fetch;
    logic io_halt;
    logic bus_grant_en;
    sccr_lp_mode_type mode;
    logic osc_on;
    logic clk_on;
    logic grant_ok;
    sccr_lp_state_type state;

    modport regs (output sleep_fetch, io_halt, bus_grant_en, mode,
                  input osc_on, clk_on, grant_ok, state);
    modport lowpower (input sleep_fetch, io_halt, bus_grant_en, mode,
                      output osc_on, clk_on, grant_ok, state);
endinterface

// ### sccr_lowpower.sv
/*
 * Low-power sequencer: idle, standby and quick-recovery standby entry,
 * wake-up and clock recovery timing.
 * Assumes bus request and external interrupt come straight from pins.
 */
`timescale 1ns/1ps
module sccr_lowpower
    import sccr_pkg::*;
#(
    parameter int unsigned STANDBY_CYCLES = STANDBY_WAKE_CYCLES
)
(
    input wire logic clock, // System clock
    input wire logic reset, // Synchronous, active high
    input wire logic bus_request_in, // Asynchronous pin
    input wire logic ext_interrupt, // Asynchronous pin
    sccr_lp_if.lowpower lp // Register side
);

    typedef struct packed {
        logic breq_s1;
        logic breq_s2;
        logic irq_s1;
        logic irq_s2;
        sccr_lp_state_type state;
        sccr_lp_mode_type kind;
        logic [CNT_W-1:0] cnt;
        logic osc_on;
        logic clk_on;
        logic grant_ok;
    } sccr_lp_regs_type;

    localparam sccr_lp_regs_type LP_RESET = '{
        breq_s1: 1'b0, breq_s2: 1'b0, irq_s1: 1'b0, irq_s2: 1'b0,
        state: LPS_RUN, kind: LP_NONE, cnt: '0,
        osc_on: 1'b1, clk_on: 1'b1, grant_ok: 1'b1};

    sccr_lp_regs_type r_r;
    sccr_lp_regs_type r_nxt;
    logic wake;

    // Idle wakes on any bus request; standby only when allowed to.
    assign wake = r_r.irq_s2
        | (r_r.breq_s2 & ((r_r.kind == LP_IDLE) | lp.bus_grant_en));

    always_comb
    begin
        r_nxt = r_r;
        r_nxt.breq_s1 = bus_request_in;
        r_nxt.breq_s2 = r_r.breq_s1;
        r_nxt.irq_s1 = ext_interrupt;
        r_nxt.irq_s2 = r_r.irq_s1;
        unique case (r_r.state)
            LPS_RUN:
            begin
                if (lp.sleep_fetch && lp.io_halt && lp.mode != LP_NONE)
                begin
                    r_nxt.state = LPS_ASLEEP;
                    r_nxt.kind = lp.mode;
                    r_nxt.clk_on = 1'b0;
                    r_nxt.grant_ok = 1'b0;
                    r_nxt.osc_on = (lp.mode == LP_IDLE);
                end
            end
            LPS_ASLEEP:
            begin
                if (wake)
                begin
                    r_nxt.state = LPS_RECOVER;
                    r_nxt.osc_on = 1'b1;
                    // Loaded one short so the clock returns exactly N
                    // cycles after the wake condition is seen.
                    if (r_r.kind == LP_IDLE)
                        r_nxt.cnt = CNT_W'(IDLE_WAKE_CYCLES - 1);
                    else if (r_r.kind == LP_QUICK)
                        r_nxt.cnt = CNT_W'(QUICK_WAKE_CYCLES - 1);
                    else
                        r_nxt.cnt = CNT_W'(STANDBY_CYCLES - 1);
                end
            end
            LPS_RECOVER:
            begin
                if (r_r.cnt <= CNT_W'(1))
                begin
                    r_nxt.state = LPS_RUN;
                    r_nxt.clk_on = 1'b1;
                    r_nxt.grant_ok = 1'b1;
                    r_nxt.cnt = '0;
                end
                else
                    r_nxt.cnt = r_r.cnt - CNT_W'(1);
            end
            default:
                r_nxt = LP_RESET;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (reset)
            r_r <= LP_RESET;
        else
            r_r <= r_nxt;
    end

    assign lp.osc_on = r_r.osc_on;
    assign lp.clk_on = r_r.clk_on;
    assign lp.grant_ok = r_r.grant_ok;
    assign lp.state = r_r.state;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    a_idle_osc_runs: assert property (
        r_r.state == LPS_ASLEEP && r_r.kind == LP_IDLE
        |-> r_r.osc_on && !r_r.clk_on)
        else $error("idle must keep oscillator and stop clocks");
    a_standby_osc_stops: assert property (
        r_r.state == LPS_ASLEEP && r_r.kind != LP_IDLE |-> !r_r.osc_on)
        else $error("standby must stop the oscillator");
    a_entry_needs_halt: assert property (
        r_r.state == LPS_RUN && !(lp.sleep_fetch && lp.io_halt)
        |=> r_r.state == LPS_RUN)
        else $error("low-power entry without fetch and halt bit");
    a_no_mode_stays: assert property (
        r_r.state == LPS_RUN && lp.mode == LP_NONE |=> r_r.clk_on)
        else $error("clocks stopped with no low-power mode");
    a_quick_recover: assert property (
        r_r.state == LPS_ASLEEP && r_r.kind == LP_QUICK && wake
        |-> ##63 r_r.state == LPS_RECOVER ##1 r_r.state == LPS_RUN)
        else $error("quick recovery not 64 cycles");
    a_idle_recover: assert property (
        r_r.state == LPS_ASLEEP && r_r.kind == LP_IDLE && wake
        |-> ##7 !r_r.clk_on ##1 r_r.clk_on)
        else $error("idle recovery not 8 cycles");
    a_grant_after_timer: assert property (
        r_r.grant_ok |-> r_r.state == LPS_RUN && r_r.clk_on)
        else $error("bus grant before recovery timer expired");

endmodule // sccr_lowpower

// ### sccr_regs.sv
/*
 * System control and configuration registers: CPU control, system
 * configuration, I/O halt bit, RAM bounds, clock divide, low-noise
 * pad controls, pin-mux and mode selects, interrupt daisy chain.
 * Assumes a same-clock 8-bit I/O bus with one-cycle read and write
 * strobes; bus request and external interrupt are raw pins.
 */
// Overview of operation
// - CPU control bit 7 zero halves internal clock, one passes it.
// - Reset clears the divide select, starting in divide-by-two.
// - Select 0,1 enables idle: oscillator runs, internal clocks stop.
// - Low-power entry only after second sleep opcode with halt bit set.
// - Select 1,0 enables standby: oscillator stops entirely.
// - Select 1,1 is standby with recovery ending after 64 cycles.
// - Bit 5 lets standby honour bus request after recovery timer.
// - Bit 4 puts the clock output pad at quarter drive.
// - Bit 1 puts the control pin group at quarter drive.
// - Bit 0 puts address and data drivers at quarter drive.
// - Config bit 3 disables ROM select; else low below ROM boundary.
// - Config bits 2,1 choose the function of three shared pins.
// - Mode 0 enables both serial channels and parallel port.
// - Mode 1 keeps channel A, enables host interface only.
// - Config bit 0 picks which interrupt source leads the chain.
// - Both interrupt sources share the single interrupt-0 line.
// - The halt bit is bit 5 of the I/O control register at 3FH.
// - Idle exits at once on reset, on request or interrupt after eight cycles.
`timescale 1ns/1ps
module sccr_regs
    import sccr_pkg::*;
#(
    parameter int unsigned STANDBY_CYCLES = STANDBY_WAKE_CYCLES
)
(
    input wire logic CLOCK, // System clock, 40 MHz
    input wire logic RESET, // Synchronous, active high
    input wire logic [7:0] IO_ADDR, // Low I/O address bits
    input wire logic [7:0] IO_WDATA, // Write data
    input wire logic IO_WR, // One-cycle write strobe
    input wire logic IO_RD, // One-cycle read strobe
    output logic [7:0] IO_RDATA, // Read data, one cycle after strobe
    output logic IO_HIT, // Read hit a mapped register
    input wire logic SLEEP_FETCH2, // Second sleep opcode fetched
    input wire logic [7:0] MEM_ADDR_HI, // Upper memory address byte
    input wire logic [7:0] ROM_BOUNDARY, // ROM boundary value
    input wire logic BUS_REQUEST_IN, // External bus request pin
    input wire logic EXT_INTERRUPT, // External interrupt pin
    input wire logic SERIAL_IRQ, // Serial controller request
    input wire logic HOST_IRQ, // Host interface request
    input wire logic INT_ACK, // Interrupt acknowledge cycle
    output logic CLK_PHASE_EN, // Internal clock enable pulse
    output logic OSC_ENABLE, // Oscillator runs
    output logic CLK_ENABLE, // Internal and gated clocks run
    output logic BUS_GRANT_ALLOWED, // Bus request may be honoured
    output logic LOW_NOISE_CLOCK_OUT, // Clock pad quarter drive
    output logic LOW_NOISE_CONTROL_PINS, // Control pads quarter drive
    output logic LOW_NOISE_ADDR_DATA, // Bus pads quarter drive
    output logic ROM_SELECT_N, // ROM chip select
    output logic [1:0] TRIMUX_SEL, // Shared pin function
    output logic CHANA_ENABLE, // Serial channel A enabled
    output logic CHANB_ENABLE, // Serial channel B outputs enabled
    output logic PARALLEL_PORT_ENABLE, // Parallel port enabled
    output logic HOST_IF_ENABLE, // Host interface enabled
    output logic CPU_INTERRUPT0_N, // Shared interrupt-0 request
    output logic SERIAL_ACK_GRANT, // Acknowledge goes to serial
    output logic HOST_ACK_GRANT, // Acknowledge goes to host
    output logic [7:0] RAM_UPPER_BOUND, // RAM upper bound register
    output logic [7:0] RAM_LOWER_BOUND // RAM lower bound register
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [7:0] cpu_control;
        logic [7:0] system_configuration;
        logic [7:0] ram_ub;
        logic [7:0] ram_lb;
        logic io_halt;
        logic [7:0] rdata;
        logic hit;
        logic phase_en;
        logic ln_clk;
        logic ln_ctrl;
        logic ln_ad;
        logic rom_sel_n;
        sccr_trimux_type trimux;
        logic cha_en;
        logic chb_en;
        logic par_en;
        logic host_en;
        logic cpu_interrupt0_n_n;
        logic ser_gnt;
        logic host_gnt;
    } sccr_regs_type;

    localparam sccr_regs_type REGS_RESET = '{
        cpu_control: CCR_RESET, system_configuration: SCR_RESET,
        ram_ub: RAM_BOUND_RESET, ram_lb: RAM_BOUND_RESET,
        io_halt: 1'b0, rdata: READ_IDLE, hit: 1'b0, phase_en: 1'b0,
        ln_clk: 1'b0, ln_ctrl: 1'b0, ln_ad: 1'b0, rom_sel_n: 1'b1,
        trimux: TRIMUX_DMA, cha_en: 1'b1, chb_en: 1'b1, par_en: 1'b1,
        host_en: 1'b0, cpu_interrupt0_n_n: 1'b1, ser_gnt: 1'b0, host_gnt: 1'b0};

    sccr_regs_type r_r;
    sccr_regs_type r_nxt;
    logic [7:0] status_word;
    logic host_first;

    sccr_lp_if lp ();

    // ************************************************************
    // Low-power sequencer
    // ************************************************************
    assign lp.sleep_fetch = SLEEP_FETCH2;
    assign lp.io_halt = r_r.io_halt;
    assign lp.bus_grant_en = r_r.cpu_control[CCR_BUS_GRANT_BIT];
    assign lp.mode = sccr_lp_mode_type'({r_r.cpu_control[CCR_LP_HI_BIT],
                                         r_r.cpu_control[CCR_LP_LO_BIT]});

    sccr_lowpower #(
        .STANDBY_CYCLES(STANDBY_CYCLES)
    ) u_lowpower (
        .clock(CLOCK),
        .reset(RESET),
        .bus_request_in(BUS_REQUEST_IN),
        .ext_interrupt(EXT_INTERRUPT),
        .lp(lp)
    );

    assign status_word = {4'h0, lp.state, lp.grant_ok, lp.osc_on};
    assign host_first = r_r.system_configuration[SCR_DAISY_BIT];

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        r_nxt = r_r;
        // Writes.
        if (IO_WR)
        begin
            unique case (IO_ADDR)
                ADDR_CPU_CONTROL:
                    r_nxt.cpu_control = IO_WDATA & CCR_WRITE_MASK;
                ADDR_SYS_CONFIG:
                    r_nxt.system_configuration = IO_WDATA;
                ADDR_RAM_UPPER:
                    r_nxt.ram_ub = IO_WDATA;
                ADDR_RAM_LOWER:
                    r_nxt.ram_lb = IO_WDATA;
                ADDR_IO_CONTROL:
                    r_nxt.io_halt = IO_WDATA[ICR_IO_HALT_BIT];
                default:
                    r_nxt.io_halt = r_r.io_halt;
            endcase
        end
        // Reads see the value before a same-cycle write.
        r_nxt.rdata = READ_IDLE;
        r_nxt.hit = 1'b0;
        if (IO_RD)
        begin
            r_nxt.hit = 1'b1;
            unique case (IO_ADDR)
                ADDR_CPU_CONTROL:
                    r_nxt.rdata = r_r.cpu_control & CCR_WRITE_MASK;
                ADDR_SYS_CONFIG:
                    r_nxt.rdata = r_r.system_configuration;
                ADDR_RAM_UPPER:
                    r_nxt.rdata = r_r.ram_ub;
                ADDR_RAM_LOWER:
                    r_nxt.rdata = r_r.ram_lb;
                ADDR_IO_CONTROL:
                    r_nxt.rdata[ICR_IO_HALT_BIT] = r_r.io_halt;
                ADDR_LP_STATUS:
                    r_nxt.rdata = status_word;
                default:
                    r_nxt.hit = 1'b0;
            endcase
        end

        // Clock divide: a steady enable in divide-by-one, alternate
        // cycles in divide-by-two, none while clocks are stopped.
        if (!lp.clk_on)
            r_nxt.phase_en = 1'b0;
        else if (r_r.cpu_control[CCR_CLK_DIV1_BIT])
            r_nxt.phase_en = 1'b1;
        else
            r_nxt.phase_en = ~r_r.phase_en;

        // Pad drive follows the register from the write edge on.
        r_nxt.ln_clk = r_nxt.cpu_control[CCR_LN_CLOCK_BIT];
        r_nxt.ln_ctrl = r_nxt.cpu_control[CCR_LN_CTRL_BIT];
        r_nxt.ln_ad = r_nxt.cpu_control[CCR_LN_AD_BIT];

        // ROM select is decoded on the address seen this cycle.
        if (r_r.system_configuration[SCR_ROM_DISABLE_BIT])
            r_nxt.rom_sel_n = 1'b1;
        else
            r_nxt.rom_sel_n = !(MEM_ADDR_HI < ROM_BOUNDARY);

        unique case (r_nxt.system_configuration[SCR_TRIMUX_HI_BIT:SCR_MODE_BIT])
            2'b10: r_nxt.trimux = TRIMUX_CHANB;
            2'b11: r_nxt.trimux = TRIMUX_HOST;
            default: r_nxt.trimux = TRIMUX_DMA;
        endcase

        // Mode changes are not guarded; software keeps them stable
        // while the affected interfaces are busy.
        r_nxt.cha_en = 1'b1;
        r_nxt.chb_en = !r_nxt.system_configuration[SCR_MODE_BIT];
        r_nxt.par_en = !r_nxt.system_configuration[SCR_MODE_BIT];
        r_nxt.host_en = r_nxt.system_configuration[SCR_MODE_BIT];

        // Daisy chain: one line, acknowledge to the leading requester.
        r_nxt.cpu_interrupt0_n_n = !(SERIAL_IRQ | HOST_IRQ);
        r_nxt.ser_gnt = INT_ACK & SERIAL_IRQ
            & !(host_first & HOST_IRQ);
        r_nxt.host_gnt = INT_ACK & HOST_IRQ
            & !(!host_first & SERIAL_IRQ);
    end

    always_ff @(posedge CLOCK)
    begin
        if (RESET)
            r_r <= REGS_RESET;
        else
            r_r <= r_nxt;
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign IO_RDATA = r_r.rdata;
    assign IO_HIT = r_r.hit;
    assign CLK_PHASE_EN = r_r.phase_en;
    assign OSC_ENABLE = lp.osc_on;
    assign CLK_ENABLE = lp.clk_on;
    assign BUS_GRANT_ALLOWED = lp.grant_ok;
    assign LOW_NOISE_CLOCK_OUT = r_r.ln_clk;
    assign LOW_NOISE_CONTROL_PINS = r_r.ln_ctrl;
    assign LOW_NOISE_ADDR_DATA = r_r.ln_ad;
    assign ROM_SELECT_N = r_r.rom_sel_n;
    assign TRIMUX_SEL = r_r.trimux;
    assign CHANA_ENABLE = r_r.cha_en;
    assign CHANB_ENABLE = r_r.chb_en;
    assign PARALLEL_PORT_ENABLE = r_r.par_en;
    assign HOST_IF_ENABLE = r_r.host_en;
    assign CPU_INTERRUPT0_N = r_r.cpu_interrupt0_n_n;
    assign SERIAL_ACK_GRANT = r_r.ser_gnt;
    assign HOST_ACK_GRANT = r_r.host_gnt;
    assign RAM_UPPER_BOUND = r_r.ram_ub;
    assign RAM_LOWER_BOUND = r_r.ram_lb;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RESET);

    a_div_two_toggles: assert property (
        lp.clk_on && !r_r.cpu_control[CCR_CLK_DIV1_BIT] && r_r.phase_en
        |=> !CLK_PHASE_EN)
        else $error("divide-by-two enable did not alternate");
    a_div_one_steady: assert property (
        lp.clk_on && r_r.cpu_control[CCR_CLK_DIV1_BIT] |=> CLK_PHASE_EN)
        else $error("divide-by-one enable not steady");
    a_reserved_reads_zero: assert property (
        IO_RD && IO_ADDR == ADDR_CPU_CONTROL |=> !IO_RDATA[2])
        else $error("reserved control bit read as one");
    a_ln_follows_write: assert property (
        IO_WR && IO_ADDR == ADDR_CPU_CONTROL
        |=> LOW_NOISE_CLOCK_OUT == $past(IO_WDATA[CCR_LN_CLOCK_BIT]))
        else $error("clock pad drive did not follow write");
    a_rom_disabled: assert property (
        r_r.system_configuration[SCR_ROM_DISABLE_BIT] |=> ROM_SELECT_N)
        else $error("ROM select active while disabled");
    a_mode_one_ports: assert property (
        r_r.system_configuration[SCR_MODE_BIT] |-> HOST_IF_ENABLE && !CHANB_ENABLE
        && !PARALLEL_PORT_ENABLE && CHANA_ENABLE)
        else $error("mode 1 enables wrong");
    a_cpu_interrupt0_n_merge: assert property (
        HOST_IRQ || SERIAL_IRQ |=> !CPU_INTERRUPT0_N)
        else $error("interrupt request not on shared line");
    a_daisy_host_first: assert property (
        INT_ACK && HOST_IRQ && SERIAL_IRQ && host_first
        |=> HOST_ACK_GRANT && !SERIAL_ACK_GRANT)
        else $error("daisy chain priority wrong");

endmodule // sccr_regs

// ### system_control_config_regs_tb.sv
/*
 * Self-checking bench for the system control and configuration registers.
 * Assumes sccr_regs and sccr_pkg are compiled first; bench is the only bus.
 */
`timescale 1ns/1ps
module system_control_config_regs_tb;
    import sccr_pkg::*;
    // ************************************************************
    // Signals and design
    // ************************************************************
    logic clock = 0, reset = 1, wr = 0, rd = 0, slp = 0, breq = 0;
    logic eint = 0, sirq = 0, hirq = 0, iack = 0;
    logic [7:0] addr = 8'h00, wdat = 8'h00, mhi = 8'h00, romb = 8'h00;
    logic [7:0] rdat, ramu, raml, v;
    logic [1:0] tmx;
    logic hit, ph, osc, clke, bga, lnc, lnp, lna, rom_n, cha, chb, par;
    logic hst, cpu_interrupt0_n_n, sgr, hgr, h;
    int fail_count = 0, cmp_count = 0, cyc = 0, k;
    localparam logic [7:0] TA [9] = '{ADDR_CPU_CONTROL, ADDR_CPU_CONTROL,
        ADDR_SYS_CONFIG, ADDR_SYS_CONFIG, ADDR_SYS_CONFIG, ADDR_RAM_UPPER,
        ADDR_RAM_LOWER, ADDR_IO_CONTROL, 8'h10};
    localparam logic [7:0] TD [9] = '{8'hFF, 8'h13, 8'h0F, 8'h04, 8'h02,
        8'hA5, 8'h5A, 8'hFF, 8'hFF};
    localparam logic [7:0] TR [9] = '{8'hFB, 8'h13, 8'h0F, 8'h04, 8'h02,
        8'hA5, 8'h5A, 8'h20, 8'h00};
    sccr_regs #(.STANDBY_CYCLES(20)) i_dut (.CLOCK(clock), .RESET(reset),
        .IO_ADDR(addr), .IO_WDATA(wdat), .IO_WR(wr), .IO_RD(rd),
        .IO_RDATA(rdat), .IO_HIT(hit), .SLEEP_FETCH2(slp), .MEM_ADDR_HI(mhi),
        .ROM_BOUNDARY(romb), .BUS_REQUEST_IN(breq), .EXT_INTERRUPT(eint),
        .SERIAL_IRQ(sirq), .HOST_IRQ(hirq), .INT_ACK(iack),
        .CLK_PHASE_EN(ph), .OSC_ENABLE(osc), .CLK_ENABLE(clke),
        .BUS_GRANT_ALLOWED(bga), .LOW_NOISE_CLOCK_OUT(lnc),
        .LOW_NOISE_CONTROL_PINS(lnp), .LOW_NOISE_ADDR_DATA(lna),
        .ROM_SELECT_N(rom_n), .TRIMUX_SEL(tmx), .CHANA_ENABLE(cha),
        .CHANB_ENABLE(chb), .PARALLEL_PORT_ENABLE(par),
        .HOST_IF_ENABLE(hst), .CPU_INTERRUPT0_N(cpu_interrupt0_n_n),
        .SERIAL_ACK_GRANT(sgr), .HOST_ACK_GRANT(hgr),
        .RAM_UPPER_BOUND(ramu), .RAM_LOWER_BOUND(raml));
    // ************************************************************
    // Clock, timeout and tasks
    // ************************************************************
    initial forever #12.5 clock = ~clock;
    // Budget is well above the few hundred cycles the tests need.
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            fail_count++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        cmp_count++;
        if (s !== e)
        begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdat <= d;
        wr <= 1;
        @(posedge clock);
        wr <= 0;
    endtask
    task automatic rd8(input logic [7:0] a);
        @(posedge clock);
        addr <= a;
        rd <= 1;
        @(posedge clock);
        rd <= 0;
        #1 v = rdat;
        h = hit;
    endtask
    // Sleep, wake by pin, count cycles until the clocks come back.
    task automatic nap(input logic [7:0] c, input logic b, input int n);
        wr8(ADDR_CPU_CONTROL, c);
        @(posedge clock) slp <= 1;
        @(posedge clock) slp <= 0;
        #1 chk(clke, 0);
        chk(osc, c == 8'h08);
        @(posedge clock) if (b) breq <= 1; else eint <= 1;
        k = 0;
        do begin @(posedge clock); #1 k++; end while (!clke && k < 300);
        chk(k, n + 2);
        chk(bga, 1);
        breq <= 0;
        eint <= 0;
        repeat (3) @(posedge clock);
        $display("sleep test done");
    endtask
    // ************************************************************
    // Tests
    // ************************************************************
    initial
    begin
        repeat (16) @(posedge clock);
        reset <= 0;
        rd8(ADDR_CPU_CONTROL);
        chk(v, 8'h00);
        chk({h, cha, chb, par, hst, rom_n}, 8'h3D);
        for (int i = 0; i < 9; i++)
        begin
            wr8(TA[i], TD[i]);
            rd8(TA[i]);
            chk(v, TR[i]);
            chk(h, i < 8);
            if (TA[i] == ADDR_CPU_CONTROL)
                chk({lnc, lnp, lna}, {TD[i][4], TD[i][1:0]});
            if (TA[i] == ADDR_SYS_CONFIG)
            begin
                chk(tmx, TD[i][2] ? (TD[i][1] ? 2 : 1) : 0);
                chk({cha, chb, par, hst}, {1'b1, ~{2{TD[i][1]}}, TD[i][1]});
            end
        end
        chk(ramu, 8'hA5);
        chk(raml, 8'h5A);
        $display("register table done");
        wr8(ADDR_CPU_CONTROL, 8'h00);
        #1 v[0] = ph;
        @(posedge clock) #1 chk(v[0] ^ ph, 1);
        wr8(ADDR_CPU_CONTROL, 8'h80);
        @(posedge clock) #1 v[0] = ph;
        @(posedge clock) #1 chk({v[0], ph}, 8'h03);
        romb <= 8'h80;
        for (int i = 0; i < 3; i++)
        begin
            mhi <= (i == 2) ? 8'h80 : 8'h10;
            wr8(ADDR_SYS_CONFIG, (i == 1) ? 8'h08 : 8'h00);
            @(posedge clock) #1 chk(rom_n, i != 0);
        end
        sirq <= 1;
        hirq <= 1;
        for (int i = 0; i < 2; i++)
        begin
            wr8(ADDR_SYS_CONFIG, 8'(i));
            #1 chk(cpu_interrupt0_n_n, 0);
            @(posedge clock) iack <= 1;
            @(posedge clock) iack <= 0;
            #1 chk({sgr, hgr}, i ? 8'h01 : 8'h02);
        end
        sirq <= 0;
        hirq <= 0;
        $display("pins and interrupts done");
        wr8(ADDR_CPU_CONTROL, 8'h00);
        @(posedge clock) slp <= 1;
        @(posedge clock) slp <= 0;
        #1 chk(clke, 1);
        wr8(ADDR_IO_CONTROL, 8'h20);
        nap(8'h08, 1'b0, IDLE_WAKE_CYCLES);
        nap(8'h60, 1'b1, 20);
        nap(8'h48, 1'b0, QUICK_WAKE_CYCLES);
        // Standby without grant enable ignores a bus request; reset wakes.
        wr8(ADDR_CPU_CONTROL, 8'hC0);
        @(posedge clock) slp <= 1;
        @(posedge clock) slp <= 0;
        @(posedge clock) breq <= 1;
        repeat (6) @(posedge clock);
        #1 chk(clke, 0);
        rd8(ADDR_LP_STATUS);
        chk(v, 8'h04);
        reset <= 1;
        breq <= 0;
        repeat (3) @(posedge clock);
        reset <= 0;
        #1 chk({osc, clke, ph}, 8'h06);
        rd8(ADDR_CPU_CONTROL);
        chk(v, 8'h00);
        $display("reset test done");
        stop_test();
    end
endmodule // system_control_config_regs_tb
